// file: shared/seb_pkg.sv
// Constants and types shared by the serial EEPROM bus front end
//
// Contract
// (R1) Up to four devices share one bus, each told apart by its two strapped select inputs.
// (R2) The device answers only when the select bits of the bus address equal its strap levels.
// (R3) An undriven select or write-protect input counts as low.
// (R4) Command and write data bits on the data line are taken on the rising clock edge.
// (R5) Read data changes only after a falling clock edge and holds through the high phase.
// (R6) The bus controller keeps the clock line high while the bus is idle.
// (R7) The data line is only ever pulled low or released, never driven high.
// (R8) The array holds 131072 byte locations, each reached by one bus address.
// (R9) A write may carry one byte, a full 256-byte page or any part of a page.
// (R10) After a write the device programs on its own and finishes within 5 ms.
// (R11) With write protect asserted the whole array is safe from change; a page commit already started at the stop still completes.
// (R12) Write protect low allows writes and high blocks every write.
// (R13) Both random-address reads and sequential reads are supported.
// (R14) While programming, new transactions to the device are ignored.
package seb_pkg;

    // ****************************************************************
    // Array geometry
    // ****************************************************************
    localparam int unsigned ADDR_W     = 17;
    localparam int unsigned MEM_DEPTH  = 131072;
    localparam int unsigned PAGE_W     = 8;
    localparam int unsigned PAGE_BYTES = 256;

    // ****************************************************************
    // Control byte layout
    // ****************************************************************
    localparam logic [3:0] CTRL_TYPE_CODE   = 4'ha;
    localparam int unsigned CTRL_RW_BIT     = 0;
    localparam int unsigned CTRL_A16_BIT    = 1;
    localparam int unsigned CTRL_STRAP_LO_BIT = 2;
    localparam int unsigned CTRL_STRAP_HI_BIT = 3;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned WRITE_TIME_NS = 5000000;
    // Longest time: round down to whole cycles
    localparam int unsigned WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic scl;
        logic sda;
    } seb_pins_t;

    typedef struct packed {
        logic sdaOut;
        logic sdaOe;
    } seb_sda_drive_t;

endpackage : seb_pkg

// file: hdl/seb_eeprom.sv
// Two-wire serial EEPROM slave: select, bit timing, page buffer and self-timed programming
module seb_eeprom #(
    parameter int unsigned WRITE_CYCLES = seb_pkg::WRITE_CYCLES
) (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire seb_pkg::seb_pins_t      busIn,
    input  wire logic                    addrStrapLow,
    input  wire logic                    addrStrapHigh,
    input  wire logic                    writeProtect,
    output seb_pkg::seb_sda_drive_t      sdaDrive,
    output logic                         writeBusy
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (WRITE_CYCLES <= seb_pkg::PAGE_BYTES || WRITE_CYCLES > 32'h00ffffff) begin : g_chk
        $error("WRITE_CYCLES must exceed the page size and fit 24 bits");
    end
    if (seb_pkg::MEM_DEPTH != (1 << seb_pkg::ADDR_W)) begin : g_chk_depth
        $error("MEM_DEPTH must equal two to the power ADDR_W");
    end

    typedef enum logic [2:0] {
        ST_IDLE, ST_CTRL, ST_ADDR_HI, ST_ADDR_LO, ST_WRITE, ST_READ, ST_IGNORE
    } seb_state_t;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [2:0]                  sclSh_r;
    logic [2:0]                  sdaSh_r;
    logic [1:0]                  strapLoSh_r;
    logic [1:0]                  strapHiSh_r;
    logic [1:0]                  wpSh_r;
    logic                        sclRise;
    logic                        sclFall;
    logic                        startDet;
    logic                        stopDet;
    logic                        sdaBit;
    logic                        strapLo;
    logic                        strapHi;
    logic                        wpOn;

    seb_state_t                  state_r;
    logic [3:0]                  bitCnt_r;
    logic [7:0]                  shift_r;
    logic                        ackSlot_r;
    logic                        sdaOe_r;
    logic [seb_pkg::ADDR_W-1:0]  addrPtr_r;
    logic [7:0]                  txByte_r;
    logic                        masterAck_r;
    logic                        byteDone;
    logic                        ctrlMatch;
    logic                        dataAccept;
    logic [7:0]                  memRd;

    logic [7:0]                  mem [seb_pkg::MEM_DEPTH];
    logic [7:0]                  pageBuf [seb_pkg::PAGE_BYTES];
    logic [seb_pkg::PAGE_BYTES-1:0] pageValid_r;
    logic [seb_pkg::ADDR_W-seb_pkg::PAGE_W-1:0] pageBase_r;
    logic                        busy_r;
    logic [23:0]                 busyCnt_r;
    logic [seb_pkg::PAGE_W:0]    commitIdx_r;
    logic                        commitWe;

    // ****************************************************************
    // Input synchronisers and edge detection
    // ****************************************************************
    // Two flops per pin; a third stage on the bus lines gives edges
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sclSh_r     <= 3'h7;
            sdaSh_r     <= 3'h7;
            strapLoSh_r <= 2'h0;
            strapHiSh_r <= 2'h0;
            wpSh_r      <= 2'h0;
        end else begin
            sclSh_r     <= {sclSh_r[1:0], busIn.scl};
            sdaSh_r     <= {sdaSh_r[1:0], busIn.sda};
            strapLoSh_r <= {strapLoSh_r[0], addrStrapLow};
            strapHiSh_r <= {strapHiSh_r[0], addrStrapHigh};
            wpSh_r      <= {wpSh_r[0], writeProtect};
        end
    end

    // Bus events seen from the synchronised levels
    assign sclRise  = sclSh_r[1] & ~sclSh_r[2];
    assign sclFall  = ~sclSh_r[1] & sclSh_r[2];
    assign sdaBit   = sdaSh_r[1];
    assign startDet = sclSh_r[1] & sclSh_r[2] & ~sdaSh_r[1] & sdaSh_r[2];
    assign stopDet  = sclSh_r[1] & sclSh_r[2] & sdaSh_r[1] & ~sdaSh_r[2];
    // Floating pins resolve low through the pad pull-down
    assign strapLo  = strapLoSh_r[1]; // R3
    assign strapHi  = strapHiSh_r[1]; // R3
    assign wpOn     = wpSh_r[1];      // R3

    // ****************************************************************
    // Byte decisions
    // ****************************************************************
    assign byteDone  = sclFall && (bitCnt_r == 4'h8) && !ackSlot_r;
    assign ctrlMatch = (shift_r[7:4] == seb_pkg::CTRL_TYPE_CODE)
                    && (shift_r[seb_pkg::CTRL_STRAP_HI_BIT] == strapHi)
                    && (shift_r[seb_pkg::CTRL_STRAP_LO_BIT] == strapLo); // R1 R2
    assign dataAccept = byteDone && (state_r == ST_WRITE) && !wpOn && !busy_r; // R12
    assign memRd      = mem[addrPtr_r];

    // ****************************************************************
    // Bus protocol state machine
    // ****************************************************************
    // Start and stop override every state; bits counted on SCL edges
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r     <= ST_IDLE;
            bitCnt_r    <= 4'h0;
            shift_r     <= 8'h00;
            ackSlot_r   <= 1'b0;
            sdaOe_r     <= 1'b0;
            addrPtr_r   <= '0;
            txByte_r    <= 8'h00;
            masterAck_r <= 1'b0;
        end else if (startDet) begin
            state_r   <= ST_CTRL;
            bitCnt_r  <= 4'h0;
            ackSlot_r <= 1'b0;
            sdaOe_r   <= 1'b0;
        end else if (stopDet) begin
            state_r   <= ST_IDLE;
            bitCnt_r  <= 4'h0;
            ackSlot_r <= 1'b0;
            sdaOe_r   <= 1'b0;
        end else begin
            case (state_r)
                ST_CTRL, ST_ADDR_HI, ST_ADDR_LO, ST_WRITE: begin
                    if (sclRise && bitCnt_r < 4'h8 && !ackSlot_r) begin
                        shift_r  <= {shift_r[6:0], sdaBit}; // R4
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end else if (sclFall && ackSlot_r) begin
                        ackSlot_r <= 1'b0; // Release after the ack bit
                        bitCnt_r  <= 4'h0;
                        sdaOe_r   <= 1'b0;
                    end else if (byteDone) begin
                        case (state_r)
                            ST_CTRL: begin
                                if (ctrlMatch && !busy_r) begin // R2 R14
                                    ackSlot_r <= 1'b1;
                                    sdaOe_r   <= 1'b1; // R5
                                    if (shift_r[seb_pkg::CTRL_RW_BIT]) begin
                                        state_r <= ST_READ; // R13
                                    end else begin
                                        addrPtr_r[seb_pkg::ADDR_W-1] <=
                                            shift_r[seb_pkg::CTRL_A16_BIT]; // R8
                                        state_r <= ST_ADDR_HI;
                                    end
                                end else begin
                                    state_r <= ST_IGNORE;
                                end
                            end
                            ST_ADDR_HI: begin
                                ackSlot_r        <= 1'b1;
                                sdaOe_r          <= 1'b1;
                                addrPtr_r[15:8]  <= shift_r; // R8
                                state_r          <= ST_ADDR_LO;
                            end
                            ST_ADDR_LO: begin
                                ackSlot_r       <= 1'b1;
                                sdaOe_r         <= 1'b1;
                                addrPtr_r[7:0]  <= shift_r; // R8 R13
                                state_r         <= ST_WRITE;
                            end
                            default: begin
                                if (dataAccept) begin
                                    ackSlot_r      <= 1'b1;
                                    sdaOe_r        <= 1'b1;
                                    addrPtr_r[7:0] <= addrPtr_r[7:0] + 8'h01; // R9
                                end else begin
                                    state_r <= ST_IGNORE; // R11 R12
                                end
                            end
                        endcase
                    end
                end
                ST_READ: begin
                    if (sclFall && ackSlot_r) begin
                        ackSlot_r <= 1'b0; // First byte after the control ack
                        bitCnt_r  <= 4'h0;
                        txByte_r  <= memRd;
                        sdaOe_r   <= ~memRd[7]; // R5 R7
                        addrPtr_r <= addrPtr_r + 17'h00001;
                    end else if (sclRise) begin
                        if (bitCnt_r < 4'h8) begin
                            bitCnt_r <= bitCnt_r + 4'h1;
                        end else begin
                            masterAck_r <= ~sdaBit; // R4
                            bitCnt_r    <= 4'h9;
                        end
                    end else if (sclFall) begin
                        if (bitCnt_r < 4'h8) begin
                            sdaOe_r <= ~txByte_r[3'(4'h7 - bitCnt_r)]; // R5 R7
                        end else if (bitCnt_r == 4'h8) begin
                            sdaOe_r <= 1'b0; // Controller drives its ack
                        end else if (masterAck_r) begin
                            bitCnt_r  <= 4'h0;
                            txByte_r  <= memRd;
                            sdaOe_r   <= ~memRd[7]; // R13
                            addrPtr_r <= addrPtr_r + 17'h00001;
                        end else begin
                            state_r <= ST_IGNORE;
                            sdaOe_r <= 1'b0;
                        end
                    end
                end
                default: begin
                    sdaOe_r <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Page buffer
    // ****************************************************************
    // Accepted bytes land at their in-page offset; later bytes overwrite
    always_ff @(posedge clk) begin
        if (dataAccept) begin
            pageBuf[addrPtr_r[7:0]] <= shift_r; // R9
        end
    end

    // Page base follows the accepted byte
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pageBase_r <= '0;
        end else if (dataAccept) begin
            pageBase_r <= addrPtr_r[seb_pkg::ADDR_W-1:seb_pkg::PAGE_W];
        end
    end

    // Valid mask: set by accepted bytes, cleared as the commit walks
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pageValid_r <= '0;
        end else if (dataAccept) begin
            pageValid_r[addrPtr_r[7:0]] <= 1'b1; // R9
        end else if (commitWe) begin
            pageValid_r[commitIdx_r[7:0]] <= 1'b0;
        end else if (startDet && !busy_r) begin
            pageValid_r <= '0; // New transaction drops bytes left by a blocked stop
        end
    end

    // ****************************************************************
    // Self-timed programming
    // ****************************************************************
    assign commitWe = busy_r && !commitIdx_r[seb_pkg::PAGE_W]
                   && pageValid_r[commitIdx_r[7:0]];

    // Stop after accepted data, with write protect low at the stop, starts a fixed-length busy window
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_r      <= 1'b0;
            busyCnt_r   <= 24'h000000;
            commitIdx_r <= '0;
        end else if (!busy_r) begin
            if (stopDet && (|pageValid_r) && !wpOn) begin // R10 R11
                busy_r      <= 1'b1;
                busyCnt_r   <= 24'(WRITE_CYCLES - 1);
                commitIdx_r <= '0;
            end
        end else begin
            if (!commitIdx_r[seb_pkg::PAGE_W]) begin
                commitIdx_r <= commitIdx_r + 9'h001;
            end
            if (busyCnt_r == 24'h000000) begin
                busy_r <= 1'b0; // R10 R14
            end else begin
                busyCnt_r <= busyCnt_r - 24'h000001;
            end
        end
    end

    // Array write, one byte per cycle from the page buffer
    always_ff @(posedge clk) begin
        if (commitWe) begin
            mem[{pageBase_r, commitIdx_r[7:0]}] <= pageBuf[commitIdx_r[7:0]]; // R8
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign sdaDrive.sdaOut = 1'b0; // R7
    assign sdaDrive.sdaOe  = sdaOe_r;
    assign writeBusy       = busy_r;

endmodule : seb_eeprom

// file: verif/seb_eeprom_sva.sv
// Assertion checker for the serial EEPROM bus front end
module seb_eeprom_sva #(
    parameter int unsigned WRITE_CYCLES = seb_pkg::WRITE_CYCLES
) (
    input wire logic                    clk,
    input wire logic                    reset,
    input wire seb_pkg::seb_pins_t      busIn,
    input wire logic                    addrStrapLow,
    input wire logic                    addrStrapHigh,
    input wire logic                    writeProtect,
    input wire seb_pkg::seb_sda_drive_t sdaDrive,
    input wire logic                    writeBusy
);
    // ****************************************************************
    // Helper count of programming cycles
    // ****************************************************************
    int unsigned busyCnt_r;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busyCnt_r <= 0;
        end else begin
            busyCnt_r <= writeBusy ? busyCnt_r + 1 : 0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // ****************************************************************
    // Assertions and covers
    // ****************************************************************
    open_drain_a: assert property (sdaDrive.sdaOut == 1'b0)
        else $error("data line driven high");
    oe_low_phase_a: assert property ($changed(sdaDrive.sdaOe) |-> !busIn.scl)
        else $error("data line changed while clock high");
    oe_hold_high_a: assert property ($rose(busIn.scl) |=> $stable(sdaDrive.sdaOe)[*3])
        else $error("data line moved in high phase");
    busy_bound_a: assert property (writeBusy |-> busyCnt_r < WRITE_CYCLES)
        else $error("programming overran its time");
    busy_nack_a: assert property (writeBusy |-> !$rose(sdaDrive.sdaOe))
        else $error("device answered while programming");
    busy_stop_a: assert property ($rose(writeBusy) |-> busIn.scl && busIn.sda)
        else $error("programming began without a stop");
    wp_block_a: assert property (writeProtect |-> !$rose(writeBusy))
        else $error("programming under write protect");
    reset_idle_a: assert property ($fell(reset) |-> !sdaDrive.sdaOe && !writeBusy)
        else $error("device not passive after reset");
    cover property ($fell(writeBusy));
    cover property ($rose(sdaDrive.sdaOe) && writeProtect);
    cover property ($rose(sdaDrive.sdaOe) && !busIn.scl);
endmodule : seb_eeprom_sva

bind seb_eeprom seb_eeprom_sva #(.WRITE_CYCLES(WRITE_CYCLES)) u_seb_eeprom_sva (
    .clk(clk), .reset(reset), .busIn(busIn), .addrStrapLow(addrStrapLow),
    .addrStrapHigh(addrStrapHigh), .writeProtect(writeProtect),
    .sdaDrive(sdaDrive), .writeBusy(writeBusy));

// file: verif/seb_i2c_ctrl.sv
// Bus controller model that pulls clock and data low or lets them float high
module seb_i2c_ctrl (
    input  wire logic clk,
    input  wire logic sdaWire,
    output logic      sclPull,
    output logic      sdaPull
);
    timeunit 1ns;
    timeprecision 1ps;
    // Both lines released so the bus idles high
    initial begin
        sclPull = 1'b0;
        sdaPull = 1'b0;
    end
    // Hold one pin state for n clock cycles
    task automatic drive(input logic s, input logic d, input int n);
        @(posedge clk);
        sclPull <= s;
        sdaPull <= d;
        repeat (n - 1) @(posedge clk);
    endtask : drive
    // One bit: data moves mid low phase, steady over the high phase
    task automatic bitPhase(input logic d);
        drive(1'b1, sdaPull, 2);
        drive(1'b1, d, 2);
        drive(1'b0, d, 4);
    endtask : bitPhase
    // Start with (0,1), stop with (1,0); clock left high afterwards
    task automatic cond(input logic d1, input logic d2);
        bitPhase(d1);
        drive(1'b0, d2, 4);
    endtask : cond
    task automatic recvBit(output logic b);
        bitPhase(1'b0);
        @(negedge clk);
        b = sdaWire;
    endtask : recvBit
    // Byte out MSB first; ack high when the device pulled low
    task automatic sendByte(input logic [7:0] v, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bitPhase(~v[i]);
        end
        recvBit(b);
        ack = ~b;
    endtask : sendByte
    task automatic recvByte(input logic nack, output logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            recvBit(v[i]);
        end
        bitPhase(~nack);
    endtask : recvByte
endmodule : seb_i2c_ctrl

// file: verif/seb_eeprom_tb_top.sv
// Testbench for the serial EEPROM bus front end
module seb_eeprom_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned WCYC = 300;
    logic                    clk;
    logic                    reset;
    logic                    addrStrapLow;
    logic                    addrStrapHigh;
    logic                    writeProtect;
    logic                    sclPull;
    logic                    sdaPull;
    logic                    writeBusy;
    logic                    ack;
    seb_pkg::seb_pins_t      busIn;
    seb_pkg::seb_sda_drive_t sdaDrive;
    int                      nErrors = 0;
    int                      compares = 0;
    int                      cycles = 0;
    // Pull-ups resolve both open-drain lines
    assign busIn = {~sclPull, ~(sdaPull | sdaDrive.sdaOe)};
    seb_eeprom #(.WRITE_CYCLES(WCYC)) u_seb_eeprom (.clk(clk), .reset(reset), .busIn(busIn),
        .addrStrapLow(addrStrapLow), .addrStrapHigh(addrStrapHigh),
        .writeProtect(writeProtect), .sdaDrive(sdaDrive), .writeBusy(writeBusy));
    seb_i2c_ctrl u_seb_i2c_ctrl (.clk(clk), .sdaWire(busIn.sda), .sclPull(sclPull),
        .sdaPull(sdaPull));
    initial clk = 1'b0;
    always #20 clk = ~clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            nErrors++;
            $display("mismatch at %0t: %s seen %h want %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, nErrors);
        if (nErrors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    // Control byte with chosen select bits
    function automatic logic [7:0] ctl(input logic [1:0] sel, input logic a16, input logic rw);
        return {seb_pkg::CTRL_TYPE_CODE, sel, a16, rw};
    endfunction : ctl
    task automatic ctlOut(input logic a16, input logic rw);
        u_seb_i2c_ctrl.cond(1'b0, 1'b1);
        u_seb_i2c_ctrl.sendByte(ctl({addrStrapHigh, addrStrapLow}, a16, rw), ack);
    endtask : ctlOut
    // Start a write transfer and load the pointer
    task automatic setPtr(input logic [16:0] a);
        ctlOut(a[16], 1'b0);
        check(ack, 1'b1, "ctrl ack");
        u_seb_i2c_ctrl.sendByte(a[15:8], ack);
        check(ack, 1'b1, "addr hi ack");
        u_seb_i2c_ctrl.sendByte(a[7:0], ack);
        check(ack, 1'b1, "addr lo ack");
    endtask : setPtr
    // Random read then sequential bytes, last one refused
    task automatic readRun(input logic [16:0] a, input logic [7:0] exp[$]);
        logic [7:0] v;
        setPtr(a);
        ctlOut(a[16], 1'b1);
        check(ack, 1'b1, "read ctrl ack");
        foreach (exp[i]) begin
            u_seb_i2c_ctrl.recvByte(i == exp.size() - 1, v);
            check(v, exp[i], "read data");
        end
        u_seb_i2c_ctrl.cond(1'b1, 1'b0);
    endtask : readRun
    task automatic testPageWrite();
        int n;
        setPtr(17'h100fe);
        for (int i = 0; i < 3; i++) begin
            u_seb_i2c_ctrl.sendByte(8'ha0 + 8'(i), ack);
            check(ack, 1'b1, "data ack");
        end
        u_seb_i2c_ctrl.cond(1'b1, 1'b0);
        repeat (4) @(negedge clk);
        check(writeBusy, 1'b1, "busy after stop");
        ctlOut(1'b1, 1'b0);
        check(ack, 1'b0, "poll nack");
        u_seb_i2c_ctrl.cond(1'b1, 1'b0);
        n = 0;
        while (writeBusy !== 1'b0 && n < WCYC) begin
            @(negedge clk);
            n++;
        end
        check(writeBusy, 1'b0, "busy ends");
        readRun(17'h100fe, '{8'ha0, 8'ha1});
        readRun(17'h10000, '{8'ha2});
        $display("page write test done");
    endtask : testPageWrite
    task automatic testProtect();
        logic [7:0] v;
        setPtr(17'h100fe);
        u_seb_i2c_ctrl.sendByte(8'h55, ack);
        check(ack, 1'b1, "open data ack");
        @(posedge clk);
        writeProtect <= 1'b1;
        u_seb_i2c_ctrl.cond(1'b1, 1'b0);
        repeat (8) @(negedge clk);
        check(writeBusy, 1'b0, "protect at stop");
        setPtr(17'h100fe);
        u_seb_i2c_ctrl.sendByte(8'h55, ack);
        check(ack, 1'b0, "protect nack");
        u_seb_i2c_ctrl.cond(1'b1, 1'b0);
        repeat (8) @(negedge clk);
        check(writeBusy, 1'b0, "no programming");
        @(posedge clk);
        writeProtect <= 1'b0;
        readRun(17'h100fe, '{8'ha0});
        ctlOut(1'b0, 1'b1);
        check(ack, 1'b1, "current ctrl ack");
        u_seb_i2c_ctrl.recvByte(1'b1, v);
        check(v, 8'ha1, "current read");
        u_seb_i2c_ctrl.cond(1'b1, 1'b0);
        $display("write protect test done");
    endtask : testProtect
    // Every strap setting against every select code
    task automatic testSelect();
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            addrStrapHigh <= k[1];
            addrStrapLow <= k[0];
            repeat (4) @(posedge clk);
            for (int b = 0; b < 4; b++) begin
                u_seb_i2c_ctrl.cond(1'b0, 1'b1);
                u_seb_i2c_ctrl.sendByte(ctl(2'(b), 1'b0, 1'b0), ack);
                check(ack, k == b, "select");
                u_seb_i2c_ctrl.cond(1'b1, 1'b0);
            end
        end
        // Wrong device type code with matching select bits
        u_seb_i2c_ctrl.cond(1'b0, 1'b1);
        u_seb_i2c_ctrl.sendByte(ctl({addrStrapHigh, addrStrapLow}, 1'b0, 1'b0) ^ 8'h10, ack);
        check(ack, 1'b0, "type code");
        u_seb_i2c_ctrl.cond(1'b1, 1'b0);
        $display("select test done");
    endtask : testSelect
    initial begin
        reset = 1'b1;
        addrStrapLow = 1'b1;
        addrStrapHigh = 1'b0;
        writeProtect = 1'b0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        testPageWrite();
        testProtect();
        testSelect();
        give_verdict();
    end
    // Cycle ceiling against a hung bus
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            nErrors++;
            give_verdict();
        end
    end
endmodule : seb_eeprom_tb_top
